// >>> pvcd_pkg.sv
package pvcd_pkg;

	// ****************************************************
	// Register map (byte addresses)
	// ****************************************************
	localparam logic [7:0] ADDR_CMD      = 8'h00;
	localparam logic [7:0] ADDR_P1P2LC   = 8'h04;
	localparam logic [7:0] ADDR_DATA0    = 8'h08;
	localparam logic [7:0] ADDR_DATA1    = 8'h0c;
	localparam logic [7:0] ADDR_DATA2    = 8'h10;
	localparam logic [7:0] ADDR_DATA3    = 8'h14;
	localparam logic [7:0] ADDR_STATUS   = 8'h18;
	localparam logic [7:0] ADDR_SW       = 8'h1c;
	localparam logic [7:0] ADDR_REF_LO   = 8'h20;
	localparam logic [7:0] ADDR_REF_HI   = 8'h24;
	localparam logic [7:0] ADDR_ACCESS   = 8'h28;
	localparam logic [7:0] ADDR_SESSION  = 8'h2c;

	// ****************************************************
	// Command codes and message fields
	// ****************************************************
	localparam logic [1:0] CMD_VERIFY  = 2'h1;
	localparam logic [1:0] CMD_CHANGE  = 2'h2;
	localparam logic [1:0] CMD_DISABLE = 2'h3;
	localparam logic [7:0] LC_QUERY    = 8'h00;
	localparam logic [7:0] LC_ONE_CODE = 8'h08;
	localparam logic [7:0] LC_TWO_CODE = 8'h10;
	localparam logic [7:0] P_ZERO      = 8'h00;
	localparam int         B8          = 7;
	localparam logic [1:0] B7B6_ZERO   = 2'h0;
	localparam logic [4:0] KREF_NONE   = 5'h00;

	// ****************************************************
	// Counters and status words
	// ****************************************************
	localparam logic [3:0]  RETRY_INIT   = 4'h3;
	localparam logic [3:0]  UNBLK_INIT   = 4'ha;
	localparam logic [15:0] SW_OK        = 16'h9000;
	localparam logic [11:0] SW_RETRY_HI  = 12'h63c;
	localparam logic [15:0] SW_BLOCKED   = 16'h6983;
	localparam logic [15:0] SW_COND      = 16'h6985;
	localparam logic [15:0] SW_WRONG_P   = 16'h6b00;
	localparam logic [15:0] SW_WRONG_LEN = 16'h6700;
	localparam logic [15:0] SW_REF_NF    = 16'h6a88;
	localparam logic [15:0] SW_INS_BAD   = 16'h6d00;

	typedef enum logic [1:0] {
		PVCD_IDLE  = 2'b00,
		PVCD_CHECK = 2'b01,
		PVCD_NVM   = 2'b11
	} pvcd_state_t;

	typedef struct packed {
		logic [7:0] p1;
		logic [7:0] p2;
		logic [7:0] lc;
	} pvcd_hdr_t;

	// Non-volatile code state, mirrored in flops and written back after every comparison and every unblock
	typedef struct packed {
		logic [63:0] ref_code;
		logic [3:0]  retries;
		logic        disabled;
		logic [4:0]  repl_kref;
	} pvcd_nv_t;

endpackage : pvcd_pkg

// >>> pvcd_core.sv
// Design decisions made here: the register offsets and register access over APB.
`timescale 1ns/100ps
// Contract
// - Verify compares only when the code is neither disabled nor blocked.
// - Code-guarded access needs a successful verify, unless the code is disabled.
// - A correct verify restores the retry counter to three.
// - Each wrong code decrements; at zero the code blocks until unblock.
// - Verify with empty data returns 63CX with remaining retries.
// - Every failed comparison reports 63CX with remaining retries.
// - P2 b8 picks global or specific data (the core ignores P2 b8 and checks one ref_code for both); P2 of zero unsupported.
// - P2 low five bits are key number 01..1F; b7 b6 zero.
// - Change needs old and new code; refused when disabled or blocked.
// - Change: correct old code resets to three and stores new code.
// - Disable is refused when already disabled or blocked.
// - Disable: correct resets to three and disables; wrong decrements.
// - After disable, guarded files open unless a replacement was asked.
// - With replacement, sole-code files need the alternate key; multi-key files open.
// - With replacement, the alternate key verify grants application access.
// - Disable P1 00, or b8 set with replacement key 01..1F, b7 b6 zero.
// - Unblock resets retries to three, unblock counter to ten, enables, grants.
module pvcd_core (
	input  wire logic        sys_clk_i,
	input  wire logic        resetn_i,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Non-volatile image: loaded at power-up, written back on nv_we_o
	input  wire logic [73:0] nv_load_i,
	input  wire logic        nv_load_valid_i,
	output logic      [73:0] nv_data_o,
	output logic             nv_we_o,
	input  wire logic        nv_done_i,
	// Unblock outcome from the unblock handler
	input  wire logic        unblock_ok_i,
	input  wire logic [63:0] unblock_new_code_i,
	// Access query for the selected file
	input  wire logic        file_needs_code_i,
	input  wire logic        file_multi_key_i,
	input  wire logic        alt_key_verified_i,
	output logic             access_granted_o,
	output logic             busy_o
);

	// ****************************************************
	// State
	// ****************************************************
	typedef struct packed {
		pvcd_pkg::pvcd_state_t state;
		pvcd_pkg::pvcd_nv_t    nv;
		pvcd_pkg::pvcd_hdr_t   hdr;
		logic [1:0]            cmd;
		logic [127:0]          data;
		logic [15:0]           sw;
		logic                  verified;
		logic                  repl_active;
		logic [3:0]            unblk_retries;
		logic                  nv_we;
	} pvcd_regs_t;

	pvcd_regs_t s_q, s_d;

	localparam int B8 = pvcd_pkg::B8;

	function automatic logic kref_ok(input logic [7:0] p);
		kref_ok = (p[6:5] == pvcd_pkg::B7B6_ZERO) && (p[4:0] != pvcd_pkg::KREF_NONE);
	endfunction : kref_ok

	logic        blocked;
	logic        hit;
	logic        wr;
	logic        rd;
	logic        p2_ok;
	logic        p1_ok;
	logic        lc_ok;
	logic [3:0]  dec_retries;

	assign blocked     = (s_q.nv.retries == 4'h0);
	assign hit         = (s_q.data[127:64] == s_q.nv.ref_code);
	assign dec_retries = blocked ? 4'h0 : s_q.nv.retries - 4'h1;
	assign wr          = psel && penable && pwrite && (s_q.state == pvcd_pkg::PVCD_IDLE);
	assign rd          = psel && penable && !pwrite;
	assign p2_ok       = kref_ok(s_q.hdr.p2) && (s_q.hdr.p2 != pvcd_pkg::P_ZERO);

	always_comb begin
		p1_ok = 1'b0;
		lc_ok = 1'b0;
		unique case (s_q.cmd)
			pvcd_pkg::CMD_VERIFY: begin
				p1_ok = (s_q.hdr.p1 == pvcd_pkg::P_ZERO);
				lc_ok = (s_q.hdr.lc == pvcd_pkg::LC_QUERY) ||
					(s_q.hdr.lc == pvcd_pkg::LC_ONE_CODE);
			end
			pvcd_pkg::CMD_CHANGE: begin
				p1_ok = (s_q.hdr.p1 == pvcd_pkg::P_ZERO);
				lc_ok = (s_q.hdr.lc == pvcd_pkg::LC_TWO_CODE);
			end
			pvcd_pkg::CMD_DISABLE: begin
				p1_ok = (s_q.hdr.p1 == pvcd_pkg::P_ZERO) ||
					(s_q.hdr.p1[B8] && kref_ok(s_q.hdr.p1));
				lc_ok = (s_q.hdr.lc == pvcd_pkg::LC_ONE_CODE);
			end
			default: begin
				p1_ok = 1'b0;
				lc_ok = 1'b0;
			end
		endcase
	end

	// ****************************************************
	// Next state
	// ****************************************************
	always_comb begin
		s_d       = s_q;
		s_d.nv_we = 1'b0;
		if (nv_load_valid_i) begin
			s_d.nv = pvcd_pkg::pvcd_nv_t'(nv_load_i);
			s_d.repl_active = (s_d.nv.repl_kref != pvcd_pkg::KREF_NONE);
		end
		if (unblock_ok_i) begin
			s_d.nv.retries     = pvcd_pkg::RETRY_INIT;
			s_d.unblk_retries  = pvcd_pkg::UNBLK_INIT;
			s_d.nv.disabled    = 1'b0;
			s_d.nv.ref_code    = unblock_new_code_i;
			s_d.nv.repl_kref   = pvcd_pkg::KREF_NONE;
			s_d.repl_active    = 1'b0;
			s_d.verified       = 1'b1;
			s_d.nv_we          = 1'b1;
			// Stay busy until the store confirms, as for a compare, unless a command write in this same cycle moves the state to CHECK
			s_d.state          = pvcd_pkg::PVCD_NVM;
		end
		if (wr) begin
			unique case (paddr)
				pvcd_pkg::ADDR_P1P2LC: s_d.hdr = pvcd_pkg::pvcd_hdr_t'(pwdata[23:0]);
				pvcd_pkg::ADDR_DATA0:  s_d.data[127:96] = pwdata;
				pvcd_pkg::ADDR_DATA1:  s_d.data[95:64]  = pwdata;
				pvcd_pkg::ADDR_DATA2:  s_d.data[63:32]  = pwdata;
				pvcd_pkg::ADDR_DATA3:  s_d.data[31:0]   = pwdata;
				pvcd_pkg::ADDR_SESSION: begin
					// A same-cycle unblock keeps the grant: set wins over clear
					if (!unblock_ok_i)
						s_d.verified = 1'b0;
				end
				pvcd_pkg::ADDR_CMD: begin
					s_d.cmd   = pwdata[1:0];
					s_d.state = pvcd_pkg::PVCD_CHECK;
				end
				default: ;
			endcase
		end
		unique case (s_q.state)
			pvcd_pkg::PVCD_IDLE: ;
			pvcd_pkg::PVCD_CHECK: begin
				s_d.state = pvcd_pkg::PVCD_IDLE;
				if (s_q.cmd == 2'h0)
					s_d.sw = pvcd_pkg::SW_INS_BAD;
				else if (!p1_ok || !p2_ok)
					s_d.sw = pvcd_pkg::SW_WRONG_P;
				else if (!lc_ok)
					s_d.sw = pvcd_pkg::SW_WRONG_LEN;
				else if (s_q.cmd == pvcd_pkg::CMD_VERIFY &&
					s_q.hdr.lc == pvcd_pkg::LC_QUERY)
					s_d.sw = {pvcd_pkg::SW_RETRY_HI, s_q.nv.retries};
				else if (blocked)
					s_d.sw = pvcd_pkg::SW_BLOCKED;
				else if (s_q.nv.disabled)
					s_d.sw = pvcd_pkg::SW_COND;
				else begin
					s_d.state = pvcd_pkg::PVCD_NVM;
					s_d.nv_we = 1'b1;
					if (hit) begin
						s_d.nv.retries = pvcd_pkg::RETRY_INIT;
						s_d.sw         = pvcd_pkg::SW_OK;
						s_d.verified   = 1'b1;
						if (s_q.cmd == pvcd_pkg::CMD_CHANGE)
							s_d.nv.ref_code = s_q.data[63:0];
						if (s_q.cmd == pvcd_pkg::CMD_DISABLE) begin
							s_d.nv.disabled  = 1'b1;
							s_d.nv.repl_kref = s_q.hdr.p1[B8] ? s_q.hdr.p1[4:0]
								: pvcd_pkg::KREF_NONE;
							s_d.repl_active  = s_q.hdr.p1[B8];
						end
					end else begin
						s_d.nv.retries = dec_retries;
						s_d.sw = {pvcd_pkg::SW_RETRY_HI, dec_retries};
						if (dec_retries == 4'h0)
							s_d.verified = 1'b0;
					end
				end
			end
			pvcd_pkg::PVCD_NVM: begin
				if (nv_done_i)
					s_d.state = pvcd_pkg::PVCD_IDLE;
			end
			default: s_d.state = pvcd_pkg::PVCD_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk_i) begin
		if (!resetn_i) begin
			s_q.state         <= pvcd_pkg::PVCD_IDLE;
			s_q.nv            <= '0;
			s_q.hdr           <= '0;
			s_q.cmd           <= 2'h0;
			s_q.data          <= '0;
			s_q.sw            <= pvcd_pkg::SW_OK;
			s_q.verified      <= 1'b0;
			s_q.repl_active   <= 1'b0;
			s_q.unblk_retries <= pvcd_pkg::UNBLK_INIT;
			s_q.nv_we         <= 1'b0;
		end else begin
			s_q <= s_d;
		end
	end

	// ****************************************************
	// Access decision
	// ****************************************************
	always_comb begin
		if (!file_needs_code_i)
			access_granted_o = 1'b1;
		else if (s_q.nv.disabled && s_q.repl_active && !file_multi_key_i)
			access_granted_o = alt_key_verified_i;
		else if (s_q.nv.disabled)
			access_granted_o = 1'b1;
		else
			access_granted_o = s_q.verified && !blocked;
	end

	// ****************************************************
	// APB slave: writes wait in IDLE so compare commits are never overtaken; a write in the same cycle as an unblock is still taken
	// ****************************************************
	assign pready    = !(psel && penable && pwrite) || (s_q.state == pvcd_pkg::PVCD_IDLE);
	assign pslverr   = 1'b0;
	assign busy_o    = (s_q.state != pvcd_pkg::PVCD_IDLE);
	assign nv_data_o = s_q.nv;
	assign nv_we_o   = s_q.nv_we;

	always_comb begin
		prdata = 32'h0000_0000;
		if (rd) begin
			unique case (paddr)
				pvcd_pkg::ADDR_STATUS: prdata = {20'h00000, s_q.unblk_retries, s_q.nv.retries,
					s_q.repl_active, s_q.verified, s_q.nv.disabled, blocked};
				pvcd_pkg::ADDR_SW:      prdata = {16'h0000, s_q.sw};
				pvcd_pkg::ADDR_P1P2LC:  prdata = {8'h00, s_q.hdr};
				pvcd_pkg::ADDR_ACCESS:  prdata = {27'h0000000, s_q.nv.repl_kref};
				default:                prdata = 32'h0000_0000;
			endcase
		end
	end

endmodule : pvcd_core

// >>> pvcd_chk_assertions.sv
`timescale 1ns/100ps
module pvcd_chk (
	input wire logic        sys_clk_i,
	input wire logic        resetn_i,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        nv_we_o,
	input wire logic        busy_o,
	input wire logic        file_needs_code_i,
	input wire logic        access_granted_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!resetn_i);
	wire logic rd = psel && penable && !pwrite;
	wire logic st = rd && paddr == 8'h18;
	read_ready_a: assert property (rd |-> pready)
		else $error("read access stalled");
	write_stall_a: assert property (psel && penable && pwrite && busy_o |-> !pready)
		else $error("write taken while busy");
	commit_pulse_a: assert property (nv_we_o |=> !nv_we_o)
		else $error("commit request longer than one cycle");
	commit_busy_a: assert property (nv_we_o |-> busy_o ##1 busy_o)
		else $error("idle while committing");
	cmd_check_a: assert property (rd == 1'b0 && psel && penable && pready && pwrite
		&& paddr == 8'h00 && pwdata[1:0] != 2'h0 |=> busy_o)
		else $error("command not checked");
	blocked_flag_a: assert property (st |-> prdata[0] == (prdata[7:4] == 4'h0))
		else $error("blocked flag disagrees with retries");
	blocked_deny_a: assert property (st && prdata[1:0] == 2'b01 && file_needs_code_i
		|-> !access_granted_o)
		else $error("access granted on blocked code");
	disabled_open_a: assert property (st && prdata[3:1] == 3'b001 && file_needs_code_i
		|-> access_granted_o)
		else $error("access refused on disabled code");
	retry_range_a: assert property (rd && paddr == 8'h1c && prdata[15:4] == 12'h63c
		|-> prdata[3:0] <= 4'h3)
		else $error("retry count out of range");
endmodule : pvcd_chk

bind pvcd_core pvcd_chk u_chk (.sys_clk_i, .resetn_i, .psel, .penable, .pwrite, .paddr,
	.pwdata, .prdata, .pready, .nv_we_o, .busy_o, .file_needs_code_i, .access_granted_o);

// >>> pvcd_nv_model.sv
`timescale 1ns/100ps
module pvcd_nv_model #(
	parameter logic [63:0] CODE  = 64'h0,
	parameter int          DELAY = 2
) (
	input  wire logic        clk_i,
	input  wire logic        we_i,
	input  wire logic [73:0] data_i,
	output logic             done_o,
	output logic      [73:0] img_o
);
	int cnt = 0;
	// No reset here: the image must outlive the core's reset
	initial begin
		done_o = 1'b0;
		img_o = {CODE, 4'h3, 1'b0, 5'h00};
	end
	always @(posedge clk_i) begin
		done_o <= (cnt == 1);
		if (we_i) begin
			img_o <= data_i;
			cnt <= DELAY;
		end else if (cnt > 0) begin
			cnt <= cnt - 1;
		end
	end
endmodule : pvcd_nv_model

// >>> testbench.sv
`timescale 1ns/100ps
module testbench;
	localparam logic [63:0] CODE = 64'h1122334455667788;
	localparam logic [63:0] NEWC = 64'h0f1e2d3c4b5a6978;
	localparam logic [23:0] HQ = 24'h008100, H1 = 24'h008108, H2 = 24'h008110;
	logic        sys_clk_i = 1'b0, resetn_i = 1'b0, psel = 1'b0, penable = 1'b0;
	logic        pwrite = 1'b0, nv_load_valid_i = 1'b0, unblock_ok_i = 1'b0;
	logic        needs = 1'b0, multi = 1'b0, alt = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic        pready, pslverr, nv_we_o, nv_done_i, busy_o, access_granted_o;
	logic [73:0] nv_load_i, nv_data_o;
	logic        err;
	logic [63:0] unblock_new_code_i = 64'h0;
	logic [15:0] sw;
	logic [11:0] st;
	int          num_errors = 0, num_checks = 0;
	always #50 sys_clk_i = ~sys_clk_i;
	pvcd_core uut (.sys_clk_i, .resetn_i, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .nv_load_i, .nv_load_valid_i, .nv_data_o, .nv_we_o, .nv_done_i,
		.unblock_ok_i, .unblock_new_code_i, .file_needs_code_i(needs), .file_multi_key_i(multi),
		.alt_key_verified_i(alt), .access_granted_o, .busy_o);
	pvcd_nv_model #(.CODE(CODE), .DELAY(3)) nv (.clk_i(sys_clk_i), .we_i(nv_we_o),
		.data_i(nv_data_o), .done_o(nv_done_i), .img_o(nv_load_i));
	task automatic complete_run();
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : complete_run
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		num_checks++;
		if (g !== e) begin
			num_errors++;
			$display("unexpected %s: expected %h seen %h", n, e, g);
		end
	endtask : chk
	// Pready and prdata are sampled mid-cycle, which is what the next rising edge takes
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk_i);
		penable <= 1'b1;
		do @(negedge sys_clk_i); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		@(posedge sys_clk_i);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge sys_clk_i);
	endtask : apb
	// The unmapped write after the command stalls until the commit is over
	task automatic run(input logic [1:0] c, input logic [23:0] h, input logic [63:0] a,
		input logic [63:0] b, input logic [15:0] e);
		apb(1'b1, 8'h04, {8'h00, h});
		apb(1'b1, 8'h08, a[63:32]);
		apb(1'b1, 8'h0c, a[31:0]);
		apb(1'b1, 8'h10, b[63:32]);
		apb(1'b1, 8'h14, b[31:0]);
		apb(1'b1, 8'h00, {30'h0, c});
		apb(1'b1, 8'h20, 32'hffffffff);
		apb(1'b0, 8'h1c, 32'h0);
		sw = rd[15:0];
		apb(1'b0, 8'h18, 32'h0);
		st = rd[11:0];
		chk("status word", e, sw);
		chk("slave error", 16'h0000, {15'h0, err});
	endtask : run
	task automatic acc(input logic n, input logic m, input logic a, input logic e);
		needs <= n;
		multi <= m;
		alt <= a;
		@(negedge sys_clk_i);
		chk("access granted", {15'h0, e}, {15'h0, access_granted_o});
		@(posedge sys_clk_i);
	endtask : acc
	task automatic boot();
		resetn_i <= 1'b0;
		repeat (20) @(posedge sys_clk_i);
		resetn_i <= 1'b1;
		nv_load_valid_i <= 1'b1;
		@(posedge sys_clk_i);
		nv_load_valid_i <= 1'b0;
		@(posedge sys_clk_i);
	endtask : boot
	task automatic unblk(input logic [63:0] c);
		unblock_new_code_i <= c;
		unblock_ok_i <= 1'b1;
		@(posedge sys_clk_i);
		unblock_ok_i <= 1'b0;
		@(posedge sys_clk_i);
	endtask : unblk
	task automatic t_verify();
		run(2'h1, HQ, 64'h0, 64'h0, 16'h63c3);
		run(2'h1, H1, CODE ^ 64'h1, 64'h0, 16'h63c2);
		run(2'h1, H1, CODE, 64'h0, 16'h9000);
		chk("status", 16'h0a34, {4'h0, st});
		acc(1'b1, 1'b0, 1'b0, 1'b1);
		apb(1'b1, 8'h2c, 32'h0);
		acc(1'b1, 1'b0, 1'b0, 1'b0);
	endtask : t_verify
	task automatic t_params();
		logic [23:0] hdr [4] = '{24'h000008, 24'h00a108, 24'h018108, 24'h008104};
		logic [15:0] exp [4] = '{16'h6b00, 16'h6b00, 16'h6b00, 16'h6700};
		for (int i = 0; i < 4; i++) begin
			run(2'h1, hdr[i], CODE, 64'h0, exp[i]);
		end
		chk("status", 16'h0a30, {4'h0, st});
	endtask : t_params
	task automatic t_change();
		run(2'h2, H2, CODE ^ 64'h0100000000000000, NEWC, 16'h63c2);
		run(2'h2, H2, CODE, NEWC, 16'h9000);
		run(2'h1, H1, CODE, 64'h0, 16'h63c2);
		run(2'h1, H1, NEWC, 64'h0, 16'h9000);
	endtask : t_change
	task automatic t_block();
		for (int i = 2; i >= 0; i--) begin
			run(2'h1, H1, CODE, 64'h0, {12'h63c, 4'(i)});
		end
		run(2'h1, H1, NEWC, 64'h0, 16'h6983);
		acc(1'b1, 1'b0, 1'b0, 1'b0);
		run(2'h2, H2, NEWC, CODE, 16'h6983);
		run(2'h3, H1, NEWC, 64'h0, 16'h6983);
		boot();
		run(2'h1, HQ, 64'h0, 64'h0, 16'h63c0);
		unblk(CODE);
		run(2'h1, HQ, 64'h0, 64'h0, 16'h63c3);
		chk("status", 16'h0a34, {4'h0, st});
		run(2'h1, H1, CODE, 64'h0, 16'h9000);
	endtask : t_block
	task automatic t_disable();
		run(2'h3, H1, NEWC, 64'h0, 16'h63c2);
		run(2'h3, H1, CODE, 64'h0, 16'h9000);
		chk("status", 16'h0a32, {4'h0, st & 12'hffb});
		apb(1'b1, 8'h2c, 32'h0);
		acc(1'b1, 1'b0, 1'b0, 1'b1);
		run(2'h3, H1, CODE, 64'h0, 16'h6985);
		run(2'h1, H1, CODE, 64'h0, 16'h6985);
		unblk(CODE);
		run(2'h3, 24'h408108, CODE, 64'h0, 16'h6b00);
		run(2'h3, 24'h858108, CODE, 64'h0, 16'h9000);
		apb(1'b0, 8'h28, 32'h0);
		chk("replacement key", 16'h0005, rd[15:0]);
		apb(1'b1, 8'h2c, 32'h0);
		acc(1'b1, 1'b0, 1'b0, 1'b0);
		acc(1'b1, 1'b0, 1'b1, 1'b1);
		acc(1'b1, 1'b1, 1'b0, 1'b1);
	endtask : t_disable
	initial begin
		repeat (8000) @(posedge sys_clk_i);
		num_errors++;
		complete_run();
	end
	initial begin
		boot();
		t_verify();
		t_params();
		t_change();
		t_block();
		t_disable();
		complete_run();
	end
endmodule : testbench
